// *** common/spd_map.svh ***
// Command codes, ranges, defaults and timing constants of the serial command decoder
`ifndef SPD_MAP_SVH
`define SPD_MAP_SVH

`define SPD_CMD_LEAD      8'hFE
`define SPD_ACK_BYTE      8'h55
`define SPD_OP_SETUP      8'h00
`define SPD_OP_PUT_A      8'h01
`define SPD_OP_PUT_B      8'h02
`define SPD_OP_PUT_C      8'h03
`define SPD_OP_SET_BIT    8'h04
`define SPD_OP_GET_BIT    8'h05
`define SPD_SUB_TEST      8'h00
`define SPD_SUB_DEFAULT   8'h01
`define SPD_SUB_GET_CFG   8'h03
`define SPD_SETBIT_LIM3   8'h30
`define SPD_SETBIT_LIM2   8'h20
`define SPD_GETBIT_LIM3   8'h18
`define SPD_GETBIT_LIM2   8'h10

`define SPD_GRP_A_CLR     3'h0
`define SPD_GRP_A_SET     3'h1
`define SPD_GRP_B_CLR     3'h2
`define SPD_GRP_B_SET     3'h3
`define SPD_GRP_C_CLR     3'h4
`define SPD_GRP_C_SET     3'h5

`define SPD_DEF_DEV_NUM   8'h00
`define SPD_DEF_DELAY     8'h96
`define SPD_DEF_HIDDEN    8'h58
`define SPD_DEF_KEYS      128'h4423_302A_4339_3837_4236_3534_4133_3231

`define SPD_SEL_DEV       5'h00
`define SPD_SEL_DELAY     5'h01
`define SPD_SEL_HIDDEN    5'h02
`define SPD_SEL_KEY0      5'h03

`define SPD_IDX_LEAD      5'h00
`define SPD_IDX_DEV       5'h01
`define SPD_IDX_DELAY     5'h02
`define SPD_IDX_KEY0      5'h03
`define SPD_IDX_HIDDEN    5'h13
`define SPD_IDX_LAST      5'h14

`define SPD_CLK_PERIOD_NS 40
`define SPD_DELAY_UNIT_NS 1000
`define SPD_DELAY_UNIT_CYC ((`SPD_DELAY_UNIT_NS + `SPD_CLK_PERIOD_NS - 1) / `SPD_CLK_PERIOD_NS)

`endif

// *** common/spd_pkg.sv ***
// Types of the serial command decoder
package spd_pkg;

  typedef enum logic [3:0] {
    SPD_IDLE  = 4'b0001,
    SPD_OPC   = 4'b0010,
    SPD_PARM  = 4'b0100,
    SPD_REPLY = 4'b1000
  } spd_state_t;

  typedef enum logic [2:0] {
    SPD_RK_ACK = 3'b001,
    SPD_RK_BIT = 3'b010,
    SPD_RK_SET = 3'b100
  } spd_reply_t;

  typedef enum logic [2:0] {
    SPD_PC_IDLE = 3'b001,
    SPD_PC_SEND = 3'b010,
    SPD_PC_GAP  = 3'b100
  } spd_pace_t;

  typedef struct packed {
    spd_state_t       state;
    logic [7:0]       opcode;
    spd_reply_t       kind;
    logic [4:0]       idx;
    logic             bit_val;
    logic [7:0]       a_out;
    logic [7:0]       a_oe;
    logic [7:0]       b_out;
    logic [7:0]       b_oe;
    logic [7:0]       c_out;
    logic [7:0]       dev_num;
    logic [7:0]       delay_nv;
    logic [7:0]       hidden;
    logic [15:0][7:0] keys;
    logic [7:0]       delay_act;
  } spd_dec_st_t;

  typedef struct packed {
    spd_pace_t   state;
    logic [7:0]  data;
    logic [23:0] cnt;
  } spd_pace_st_t;

endpackage

// *** common/spd_tx_if.sv ***
// Reply byte hand-off between the decoder and the transmit pacer
`timescale 1ns/1ns
interface spd_tx_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic [7:0] delay;

  modport dec   (output valid, output data, output delay, input ready);
  modport pacer (input valid, input data, input delay, output ready);
endinterface

// *** hw/spd_decoder.sv ***
// Serial command decoder: port writes, bit set and read, setup and settings replies
// Function
// R1 - Every command starts with byte 254; following bytes are opcode and parameters.
// R2 - Setup 0 then 0 answers with the single byte 85.
// R3 - Stored character delay spaces transmitted reply bytes; factory value is 150.
// R4 - Setup 0 then 1 restores stored defaults, replies 85, applies after power-up.
// R5 - Byte 85 is sent during configuration exchange to keep both sides in step.
// R6 - Configuration values always move one after another in a fixed order.
// R7 - Setup 0 then 3 replies 254 first, then the stored configuration.
// R8 - Settings reply: device number, then delay, then keypad codes.
// R9 - A character delay of zero sends reply bytes back to back.
// R10 - A hidden substitute character is stored to mask keypad entries on display.
// R11 - Host keeps only one controller on the line while programming settings.
// R12 - Opcode 1 makes all first-port lines outputs driving the parameter byte.
// R13 - Opcode 2 makes all second-port lines outputs driving the parameter byte.
// R14 - Opcode 3 drives the output-only third port, eight-relay variant only.
// R15 - Each port line follows the matching bit of the written byte.
// R16 - Opcode 4 values 0-7 clear, 8-15 set first-port bits.
// R17 - Opcode 4 values 16-23 clear, 24-31 set second-port bits.
// R18 - Opcode 4 values 32-39 clear, 40-47 set third-port bits, eight-relay only.
// R19 - Opcode 5 with 0-23 answers one byte, 0 or 1, the bit state.
// R20 - Opcode 5 values 0-15 turn the chosen first/second-port line into input, read it.
// R21 - Opcode 5 values 16-23 report the driven third-port bit, no direction change.
// R22 - Out-of-range opcodes, parameters, and absent third-port commands are ignored silently.
// R23 - Replies start only after the whole command has been received.
`timescale 1ns/1ns
`include "spd_map.svh"
module spd_decoder #(
  parameter bit EIGHT_RELAY = 1'b1,
  parameter int UNIT_CYC    = `SPD_DELAY_UNIT_CYC
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // Received command bytes
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_valid_i,
  // Reply bytes
  output logic [7:0]      tx_data_o,
  output logic            tx_valid_o,
  input  wire logic       tx_ready_i,
  // First and second port pins
  input  wire logic [7:0] port_a_i,
  output logic [7:0]      port_a_o,
  output logic [7:0]      port_a_oe_o,
  input  wire logic [7:0] port_b_i,
  output logic [7:0]      port_b_o,
  output logic [7:0]      port_b_oe_o,
  // Third port, output only
  output logic [7:0]      port_c_o,
  // Stored configuration access and reply busy flag
  input  wire logic       cfg_wr_i,
  input  wire logic [4:0] cfg_sel_i,
  input  wire logic [7:0] cfg_data_i,
  input  wire logic       cfg_apply_i,
  output logic [7:0]      hidden_char_o,
  output logic [7:0]      dev_num_o,
  output logic            busy_o
);

  spd_pkg::spd_dec_st_t st_r;
  spd_pkg::spd_dec_st_t st_nxt;
  spd_tx_if tx ();

  // R6 fixed order of the settings reply
  function automatic logic [7:0] reply_byte(input spd_pkg::spd_dec_st_t s);
    logic [4:0] k;
    k = s.idx - `SPD_IDX_KEY0;
    case (s.kind)
      spd_pkg::SPD_RK_ACK: reply_byte = `SPD_ACK_BYTE;
      spd_pkg::SPD_RK_BIT: reply_byte = {7'h00, s.bit_val};
      spd_pkg::SPD_RK_SET: begin
        // R7 lead byte, R8 device number then delay then keys
        if (s.idx == `SPD_IDX_LEAD) begin
          reply_byte = `SPD_CMD_LEAD;
        end else if (s.idx == `SPD_IDX_DEV) begin
          reply_byte = s.dev_num;
        end else if (s.idx == `SPD_IDX_DELAY) begin
          reply_byte = s.delay_nv;
        end else if (s.idx < `SPD_IDX_HIDDEN) begin
          reply_byte = s.keys[k[3:0]];
        end else if (s.idx == `SPD_IDX_HIDDEN) begin
          reply_byte = s.hidden;
        end else begin
          // R5 closing sync byte
          reply_byte = `SPD_ACK_BYTE;
        end
      end
      default: reply_byte = 8'h00;
    endcase
  endfunction

  function automatic logic reply_done(input spd_pkg::spd_dec_st_t s);
    if (s.kind == spd_pkg::SPD_RK_SET) begin
      reply_done = (s.idx == `SPD_IDX_LAST);
    end else begin
      reply_done = 1'b1;
    end
  endfunction

  assign tx.valid      = (st_r.state == spd_pkg::SPD_REPLY);
  assign tx.data       = reply_byte(st_r);
  assign tx.delay      = st_r.delay_act;
  assign port_a_o      = st_r.a_out;
  assign port_a_oe_o   = st_r.a_oe;
  assign port_b_o      = st_r.b_out;
  assign port_b_oe_o   = st_r.b_oe;
  assign port_c_o      = st_r.c_out;
  assign hidden_char_o = st_r.hidden;
  assign dev_num_o     = st_r.dev_num;
  assign busy_o        = (st_r.state == spd_pkg::SPD_REPLY);

  always_comb begin
    logic [2:0] grp;
    logic [2:0] bi;
    logic [4:0] ki;
    grp    = rx_data_i[5:3];
    bi     = rx_data_i[2:0];
    ki     = cfg_sel_i - `SPD_SEL_KEY0;
    st_nxt = st_r;
    // R10 stored substitute character and other settings
    if (cfg_wr_i) begin
      if (cfg_sel_i == `SPD_SEL_DEV) begin
        st_nxt.dev_num = cfg_data_i;
      end else if (cfg_sel_i == `SPD_SEL_DELAY) begin
        st_nxt.delay_nv = cfg_data_i;
      end else if (cfg_sel_i == `SPD_SEL_HIDDEN) begin
        st_nxt.hidden = cfg_data_i;
      end else if (ki < 5'h10) begin
        st_nxt.keys[ki[3:0]] = cfg_data_i;
      end
    end
    if (cfg_apply_i) begin
      st_nxt.delay_act = st_r.delay_nv;
    end
    case (st_r.state)
      spd_pkg::SPD_IDLE: begin
        // R1 wait for the command lead byte
        if (rx_valid_i && rx_data_i == `SPD_CMD_LEAD) begin
          st_nxt.state = spd_pkg::SPD_OPC;
        end
      end
      spd_pkg::SPD_OPC: begin
        if (rx_valid_i) begin
          st_nxt.opcode = rx_data_i;
          // R22 unknown opcode drops the command
          if (rx_data_i <= `SPD_OP_GET_BIT) begin
            st_nxt.state = spd_pkg::SPD_PARM;
          end else begin
            st_nxt.state = spd_pkg::SPD_IDLE;
          end
        end
      end
      spd_pkg::SPD_PARM: begin
        if (rx_valid_i) begin
          st_nxt.state = spd_pkg::SPD_IDLE;
          st_nxt.idx   = 5'h00;
          case (st_r.opcode)
            `SPD_OP_SETUP: begin
              // R2 link test
              if (rx_data_i == `SPD_SUB_TEST) begin
                st_nxt.kind  = spd_pkg::SPD_RK_ACK;
                st_nxt.state = spd_pkg::SPD_REPLY;
              // R4 factory defaults into the stored set
              end else if (rx_data_i == `SPD_SUB_DEFAULT) begin
                st_nxt.dev_num  = `SPD_DEF_DEV_NUM;
                st_nxt.delay_nv = `SPD_DEF_DELAY;
                st_nxt.hidden   = `SPD_DEF_HIDDEN;
                st_nxt.keys     = `SPD_DEF_KEYS;
                st_nxt.kind     = spd_pkg::SPD_RK_ACK;
                st_nxt.state    = spd_pkg::SPD_REPLY;
              // R7 settings report
              end else if (rx_data_i == `SPD_SUB_GET_CFG) begin
                st_nxt.kind  = spd_pkg::SPD_RK_SET;
                st_nxt.state = spd_pkg::SPD_REPLY;
              end
            end
            // R12 R15 whole first port
            `SPD_OP_PUT_A: begin
              st_nxt.a_out = rx_data_i;
              st_nxt.a_oe  = 8'hFF;
            end
            // R13 R15 whole second port
            `SPD_OP_PUT_B: begin
              st_nxt.b_out = rx_data_i;
              st_nxt.b_oe  = 8'hFF;
            end
            // R14 R22 third port only when fitted
            `SPD_OP_PUT_C: begin
              if (EIGHT_RELAY) begin
                st_nxt.c_out = rx_data_i;
              end
            end
            `SPD_OP_SET_BIT: begin
              // R22 range check depends on variant
              if (rx_data_i < (EIGHT_RELAY ? `SPD_SETBIT_LIM3 : `SPD_SETBIT_LIM2)) begin
                case (grp)
                  // R16 first port bits
                  `SPD_GRP_A_CLR, `SPD_GRP_A_SET: begin
                    st_nxt.a_out[bi] = grp[0];
                    st_nxt.a_oe[bi]  = 1'b1;
                  end
                  // R17 second port bits
                  `SPD_GRP_B_CLR, `SPD_GRP_B_SET: begin
                    st_nxt.b_out[bi] = grp[0];
                    st_nxt.b_oe[bi]  = 1'b1;
                  end
                  // R18 third port bits
                  `SPD_GRP_C_CLR, `SPD_GRP_C_SET: st_nxt.c_out[bi] = grp[0];
                  default: st_nxt.c_out = st_r.c_out;
                endcase
              end
            end
            `SPD_OP_GET_BIT: begin
              // R19 one-byte bit status, R23 after the parameter
              if (rx_data_i < (EIGHT_RELAY ? `SPD_GETBIT_LIM3 : `SPD_GETBIT_LIM2)) begin
                st_nxt.kind  = spd_pkg::SPD_RK_BIT;
                st_nxt.state = spd_pkg::SPD_REPLY;
                // R20 line becomes input and is read
                if (grp == 3'h0) begin
                  st_nxt.a_oe[bi] = 1'b0;
                  st_nxt.bit_val  = port_a_i[bi];
                end else if (grp == 3'h1) begin
                  st_nxt.b_oe[bi] = 1'b0;
                  st_nxt.bit_val  = port_b_i[bi];
                end else begin
                  // R21 driven state, direction kept
                  st_nxt.bit_val = st_r.c_out[bi];
                end
              end
            end
            default: st_nxt.state = spd_pkg::SPD_IDLE;
          endcase
        end
      end
      spd_pkg::SPD_REPLY: begin
        // R6 one byte at a time as the pacer frees up
        if (tx.ready) begin
          if (reply_done(st_r)) begin
            st_nxt.state = spd_pkg::SPD_IDLE;
          end else begin
            st_nxt.idx = st_r.idx + 5'h01;
          end
        end
      end
      default: st_nxt.state = spd_pkg::SPD_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '{state: spd_pkg::SPD_IDLE, opcode: 8'h00, kind: spd_pkg::SPD_RK_ACK,
                idx: 5'h00, bit_val: 1'b0, a_out: 8'h00, a_oe: 8'h00, b_out: 8'h00,
                b_oe: 8'h00, c_out: 8'h00, dev_num: `SPD_DEF_DEV_NUM,
                delay_nv: `SPD_DEF_DELAY, hidden: `SPD_DEF_HIDDEN, keys: `SPD_DEF_KEYS,
                delay_act: `SPD_DEF_DELAY};
    end else begin
      st_r <= st_nxt;
    end
  end

  spd_tx_pacer #(
    .UNIT_CYC (UNIT_CYC)
  ) u_pacer (
    .clock_i    (clock_i),
    .sys_rst_i  (sys_rst_i),
    .tx         (tx),
    .tx_data_o  (tx_data_o),
    .tx_valid_o (tx_valid_o),
    .tx_ready_i (tx_ready_i)
  );

  // Parameter byte of a given opcode seen this cycle
  function automatic logic parm_of(input spd_pkg::spd_dec_st_t s, input logic [7:0] op,
                                   input logic v);
    parm_of = v && s.state == spd_pkg::SPD_PARM && s.opcode == op;
  endfunction

  a_lead_needed: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R1
    (st_r.state == spd_pkg::SPD_IDLE && rx_valid_i && rx_data_i != `SPD_CMD_LEAD)
    |=> st_r.state == spd_pkg::SPD_IDLE)
    else $error("command mode entered without lead byte");
  a_test_ack: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R2
    (parm_of(st_r, `SPD_OP_SETUP, rx_valid_i) && rx_data_i == `SPD_SUB_TEST)
    |=> tx.valid && tx.data == `SPD_ACK_BYTE && st_r.kind == spd_pkg::SPD_RK_ACK)
    else $error("link test reply wrong");
  a_restore_def: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R4
    (parm_of(st_r, `SPD_OP_SETUP, rx_valid_i) && rx_data_i == `SPD_SUB_DEFAULT
     && !cfg_wr_i && !cfg_apply_i)
    |=> st_r.delay_nv == `SPD_DEF_DELAY && st_r.hidden == `SPD_DEF_HIDDEN
        && $stable(st_r.delay_act) && tx.data == `SPD_ACK_BYTE)
    else $error("defaults not restored or applied too early");
  a_settings_lead: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R7
    (parm_of(st_r, `SPD_OP_SETUP, rx_valid_i) && rx_data_i == `SPD_SUB_GET_CFG)
    |=> tx.valid && tx.data == `SPD_CMD_LEAD)
    else $error("settings reply does not open with lead byte");
  a_settings_order: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R8
    (tx.valid && tx.ready && st_r.kind == spd_pkg::SPD_RK_SET && st_r.idx <= `SPD_IDX_DEV)
    |=> tx.data == (($past(st_r.idx) == `SPD_IDX_LEAD) ? st_r.dev_num : st_r.delay_nv))
    else $error("settings reply order wrong");
  a_port_a_byte: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R12
    parm_of(st_r, `SPD_OP_PUT_A, rx_valid_i)
    |=> port_a_o == $past(rx_data_i) && port_a_oe_o == 8'hFF)
    else $error("first port byte write wrong");
  a_port_c_absent: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R22
    !EIGHT_RELAY |-> port_c_o == 8'h00)
    else $error("third port moved on sixteen-relay variant");
  a_bit_set_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R16
    (parm_of(st_r, `SPD_OP_SET_BIT, rx_valid_i) && rx_data_i[7:3] == 5'h01)
    |=> port_a_o[$past(rx_data_i[2:0])] && port_a_oe_o[$past(rx_data_i[2:0])])
    else $error("first port bit not set");
  a_bit_range: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R22
    (parm_of(st_r, `SPD_OP_SET_BIT, rx_valid_i) && rx_data_i >= `SPD_SETBIT_LIM3)
    |=> $stable(port_a_o) && $stable(port_b_o) && $stable(port_c_o))
    else $error("out-of-range bit command changed a port");
  a_read_input: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R20
    (parm_of(st_r, `SPD_OP_GET_BIT, rx_valid_i) && rx_data_i[7:3] == 5'h01)
    |=> !port_b_oe_o[$past(rx_data_i[2:0])]
        && tx.data == {7'h00, $past(port_b_i[rx_data_i[2:0]])})
    else $error("second port bit read wrong");
  a_reply_late: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R23
    $rose(tx.valid) |-> $past(st_r.state) == spd_pkg::SPD_PARM)
    else $error("reply started before command complete");

  c_test_cmd: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    tx_valid_o && tx_ready_i && tx_data_o == `SPD_ACK_BYTE);
  c_settings: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    st_r.kind == spd_pkg::SPD_RK_SET && st_r.idx == `SPD_IDX_LAST && tx.ready);
  c_bit_read: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    parm_of(st_r, `SPD_OP_GET_BIT, rx_valid_i));

endmodule

// *** hw/spd_tx_pacer.sv ***
// Transmit pacer: holds each reply byte and inserts the character delay after it
`timescale 1ns/1ns
`include "spd_map.svh"
module spd_tx_pacer #(
  parameter int UNIT_CYC = `SPD_DELAY_UNIT_CYC
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // Decoder side
  spd_tx_if.pacer   tx,
  // Serial transmitter side
  output logic [7:0] tx_data_o,
  output logic       tx_valid_o,
  input  wire logic  tx_ready_i
);

  spd_pkg::spd_pace_st_t st_r;
  spd_pkg::spd_pace_st_t st_nxt;

  assign tx.ready   = (st_r.state == spd_pkg::SPD_PC_IDLE);
  assign tx_data_o  = st_r.data;
  assign tx_valid_o = (st_r.state == spd_pkg::SPD_PC_SEND);

  always_comb begin
    st_nxt = st_r;
    case (st_r.state)
      spd_pkg::SPD_PC_IDLE: begin
        if (tx.valid) begin
          st_nxt.data  = tx.data;
          st_nxt.state = spd_pkg::SPD_PC_SEND;
        end
      end
      spd_pkg::SPD_PC_SEND: begin
        // R3 gap after each byte
        if (tx_ready_i) begin
          st_nxt.cnt = 24'(tx.delay * UNIT_CYC);
          // R9 zero delay skips the gap
          if (tx.delay == 8'h00) begin
            st_nxt.state = spd_pkg::SPD_PC_IDLE;
          end else begin
            st_nxt.state = spd_pkg::SPD_PC_GAP;
          end
        end
      end
      spd_pkg::SPD_PC_GAP: begin
        if (st_r.cnt <= 24'h00_0001) begin
          st_nxt.state = spd_pkg::SPD_PC_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - 24'h00_0001;
        end
      end
      default: st_nxt.state = spd_pkg::SPD_PC_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '{state: spd_pkg::SPD_PC_IDLE, data: 8'h00, cnt: 24'h00_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  a_gap_silent: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R3
    (st_r.state == spd_pkg::SPD_PC_GAP) |-> !tx_valid_o && !tx.ready)
    else $error("pacer offered a byte during the gap");
  a_zero_delay: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R9
    (tx_valid_o && tx_ready_i && tx.delay == 8'h00) |=> tx.ready)
    else $error("zero delay did not free the pacer at once");
  a_byte_held: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R3
    (tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte dropped before acceptance");

endmodule

// *** verif/serial_port_io_command_decoder_bench.sv ***
// Self-checking bench of the serial command decoder
`timescale 1ns/1ns
`include "spd_map.svh"
module serial_port_io_command_decoder_bench;
  logic       clock_i    = 1'b0;
  logic       sys_rst_i  = 1'b1;
  logic [7:0] rx_data_i  = 8'h00;
  logic       rx_valid_i = 1'b0;
  logic [7:0] port_a_i   = 8'h00;
  logic [7:0] port_b_i   = 8'h00;
  logic       cfg_wr_i   = 1'b0;
  logic [4:0] cfg_sel_i  = 5'h00;
  logic [7:0] cfg_data_i = 8'h00;
  logic       cfg_apply_i = 1'b0;
  logic       slow       = 1'b0;
  logic       tx_ready_i;
  logic       tx_valid_o;
  logic       busy_o;
  logic [7:0] tx_data_o, port_a_o, port_a_oe_o, port_b_o, port_b_oe_o, port_c_o;
  logic [7:0] hidden_char_o, dev_num_o;
  logic [7:0] n_port_c;
  int         bad_count = 0;
  int         n_checks  = 0;
  string      keys_s    = "123A456B789C*0#D";

  spd_decoder #(.EIGHT_RELAY(1'b1), .UNIT_CYC(1)) dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .rx_data_i(rx_data_i),
    .rx_valid_i(rx_valid_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .port_a_i(port_a_i), .port_a_o(port_a_o),
    .port_a_oe_o(port_a_oe_o), .port_b_i(port_b_i), .port_b_o(port_b_o),
    .port_b_oe_o(port_b_oe_o), .port_c_o(port_c_o), .cfg_wr_i(cfg_wr_i),
    .cfg_sel_i(cfg_sel_i), .cfg_data_i(cfg_data_i), .cfg_apply_i(cfg_apply_i),
    .hidden_char_o(hidden_char_o), .dev_num_o(dev_num_o), .busy_o(busy_o));

  // Sixteen-relay variant sees the same commands; its third port must stay still
  spd_decoder #(.EIGHT_RELAY(1'b0), .UNIT_CYC(1)) dut_n (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .rx_data_i(rx_data_i),
    .rx_valid_i(rx_valid_i), .tx_data_o(), .tx_valid_o(), .tx_ready_i(1'b1),
    .port_a_i(port_a_i), .port_a_o(), .port_a_oe_o(), .port_b_i(port_b_i),
    .port_b_o(), .port_b_oe_o(), .port_c_o(n_port_c), .cfg_wr_i(cfg_wr_i),
    .cfg_sel_i(cfg_sel_i), .cfg_data_i(cfg_data_i), .cfg_apply_i(cfg_apply_i),
    .hidden_char_o(), .dev_num_o(), .busy_o());

  spd_host_model host (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .rep_data_i(tx_data_o),
    .rep_valid_i(tx_valid_o), .rep_ready_o(tx_ready_i), .slow_i(slow));

  always #20 clock_i = ~clock_i;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] b);
    @(posedge clock_i);
    rx_data_i  <= b;
    rx_valid_i <= 1'b1;
    @(posedge clock_i);
    rx_valid_i <= 1'b0;
  endtask

  // every command opens with the lead byte
  task automatic cmd(input logic [7:0] op, input logic [7:0] p);
    send(`SPD_CMD_LEAD);
    send(op);
    send(p);
    repeat (5) @(posedge clock_i);
  endtask

  task automatic reply(input int n);
    int t;
    t = 0;
    while ((host.got.size() < n || busy_o !== 1'b0) && t < 8000) begin
      @(posedge clock_i);
      t++;
    end
    chk(8'(host.got.size()), 8'(n));
  endtask

  task automatic cfg(input logic [4:0] s, input logic [7:0] d, input logic ap);
    @(posedge clock_i);
    cfg_wr_i    <= !ap;
    cfg_apply_i <= ap;
    cfg_sel_i   <= s;
    cfg_data_i  <= d;
    @(posedge clock_i);
    cfg_wr_i    <= 1'b0;
    cfg_apply_i <= 1'b0;
  endtask

  task automatic flush();
    host.got.delete();
    host.stamp.delete();
  endtask

  // Settings reply: lead, device, delay, sixteen keys, hidden, ack
  task automatic expect_cfg(input logic [7:0] dev, input int lo, input int hi);
    logic [7:0] e[21];
    int         g;
    e[0] = `SPD_CMD_LEAD;
    e[1] = dev;
    e[2] = 8'h96;
    for (int i = 0; i < 16; i++) e[3 + i] = keys_s[i];
    e[19] = 8'h58;
    e[20] = `SPD_ACK_BYTE;
    reply(21);
    for (int i = 0; i < 21 && i < host.got.size(); i++) begin
      chk(host.got[i], e[i]);
      g = (i > 0) ? host.stamp[i] - host.stamp[i - 1] : lo;
      chk({7'h00, g >= lo && g <= hi}, 8'h01);
    end
    flush();
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clock_i);
    bad_count++;
    wrap_up();
  end

  initial begin
    logic [7:0] bp[3] = '{8'h04, 8'h0C, 8'h16};
    logic [7:0] be[3] = '{8'h01, 8'h00, 8'h01};
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    chk(port_a_oe_o | port_b_oe_o | port_c_o, 8'h00);
    chk(dev_num_o, 8'h00);
    chk({6'h00, tx_valid_o, busy_o}, 8'h00);
    chk(hidden_char_o, `SPD_DEF_HIDDEN);
    cmd(`SPD_OP_SETUP, `SPD_SUB_GET_CFG);
    expect_cfg(8'h00, 150, 100000);
    cfg(5'h00, 8'h07, 1'b0);
    cfg(5'h01, 8'h00, 1'b0);
    cfg(5'h00, 8'h00, 1'b1);
    chk(dev_num_o, 8'h07);
    cfg(5'h02, 8'h2A, 1'b0);
    @(posedge clock_i);
    chk(hidden_char_o, 8'h2A);
    send(`SPD_CMD_LEAD);
    send(`SPD_OP_SETUP);
    repeat (6) @(posedge clock_i);
    chk(8'(host.got.size()), 8'h00);
    send(`SPD_SUB_TEST);
    reply(1);
    chk(host.got[0], `SPD_ACK_BYTE);
    flush();
    cmd(`SPD_OP_SETUP, `SPD_SUB_DEFAULT);
    reply(1);
    chk(host.got[0], `SPD_ACK_BYTE);
    chk(dev_num_o, 8'h00);
    flush();
    cmd(`SPD_OP_SETUP, `SPD_SUB_GET_CFG);
    expect_cfg(8'h00, 1, 3);
    cmd(`SPD_OP_PUT_A, 8'hA5);
    cmd(`SPD_OP_PUT_B, 8'h3C);
    cmd(`SPD_OP_PUT_C, 8'h96);
    chk(port_a_o, 8'hA5);
    chk(port_a_oe_o & port_b_oe_o, 8'hFF);
    chk(port_b_o, 8'h3C);
    chk(port_c_o, 8'h96);
    cmd(`SPD_OP_SET_BIT, 8'h00);
    cmd(`SPD_OP_SET_BIT, 8'h07);
    cmd(`SPD_OP_SET_BIT, 8'h0E);
    cmd(`SPD_OP_SET_BIT, 8'h12);
    cmd(`SPD_OP_SET_BIT, 8'h1F);
    cmd(`SPD_OP_SET_BIT, 8'h21);
    cmd(`SPD_OP_SET_BIT, 8'h2E);
    cmd(`SPD_OP_SET_BIT, 8'h30);
    cmd(8'h09, 8'h11);
    chk(port_a_o, 8'h64);
    chk(port_b_o, 8'hB8);
    chk(port_c_o, 8'hD4);
    slow       <= 1'b1;
    port_a_i   <= 8'h10;
    port_b_i   <= 8'hEF;
    for (int k = 0; k < 3; k++) begin
      cmd(`SPD_OP_GET_BIT, bp[k]);
      reply(k + 1);
      chk(host.got[k], be[k]);
    end
    cmd(`SPD_OP_GET_BIT, 8'h18);
    // Slow host would take a reply late
    repeat (8) @(posedge clock_i);
    reply(3);
    chk(port_a_oe_o, 8'hEF);
    chk(port_b_oe_o, 8'hEF);
    chk(port_c_o, 8'hD4);
    chk(n_port_c, 8'h00);
    wrap_up();
  end
endmodule

// *** verif/spd_host_model.sv ***
// Host side model: takes reply bytes, can stall, logs bytes and arrival cycles
`timescale 1ns/1ns
module spd_host_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // Reply stream from the decoder
  input  wire logic [7:0] rep_data_i,
  input  wire logic       rep_valid_i,
  output logic            rep_ready_o,
  // Stall control
  input  wire logic       slow_i
);
  logic [7:0] got[$];
  int         stamp[$];
  int         cyc;
  logic [1:0] cnt_r;

  // one host, one controller on the line
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r       <= 2'h0;
      rep_ready_o <= 1'b0;
      cyc         <= 0;
    end else begin
      cnt_r       <= cnt_r + 2'h1;
      cyc         <= cyc + 1;
      // Slow host only takes a byte one cycle in four
      rep_ready_o <= !slow_i || (cnt_r == 2'h3);
      if (rep_valid_i && rep_ready_o) begin
        got.push_back(rep_data_i);
        stamp.push_back(cyc);
      end
    end
  end
endmodule
